// File: inc/hph_pkg.sv
// shared constants and carrier types of the host port handshake
package hph_pkg;
   localparam int CLK_PERIOD_NS = 50;
   // host strobe low and high time, in cpu clock periods
   localparam int STB_MIN_P = 4;
   localparam int STB_MIN_NS = STB_MIN_P * CLK_PERIOD_NS;
   // read data leads the ready edge by this much
   localparam int DATA_LEAD_NS = 100;
   localparam int DATA_LEAD_CYC = (DATA_LEAD_NS / CLK_PERIOD_NS) < 1 ? 1 : (DATA_LEAD_NS / CLK_PERIOD_NS);
   localparam int LEAD_W = 2;
   // register select codes
   localparam logic [1:0] SEL_CONTROL = 2'h0;
   localparam logic [1:0] SEL_WINDOW_AUTO = 2'h1;
   localparam logic [1:0] SEL_ADDRESS = 2'h2;
   localparam logic [1:0] SEL_WINDOW_FIXED = 2'h3;
   // positions in the synchroniser vector
   localparam int SYN_CS = 0;
   localparam int SYN_A = 1;
   localparam int SYN_B = 2;
   localparam int SYN_AS = 3;
   localparam logic [3:0] SYN_RESET = 4'hF;
   // strap bits on the data bus during reset
   localparam int CFG_ENDIAN_BIT = 8;
   localparam int CFG_BOOT_LSB = 3;
   localparam int CFG_BOOT_W = 2;
   localparam logic [15:0] DATA_RESET = 16'h0000;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;

   typedef struct packed {
      logic [1:0] sel;
      logic rnw;
      logic hw;
   } hph_select_t;

   typedef struct packed {
      hph_select_t s;
      logic [15:0] data;
   } hph_pin_t;

   typedef struct packed {
      logic [1:0] sel;
      logic [31:0] data;
   } hph_word_t;
endpackage

// File: core/hph_port.sv
// device end of the 16-bit asynchronous host port handshake
`timescale 1ns/1ns
`default_nettype none
// How it works
// - internal strobe is chip select OR not(strobe_a XOR strobe_b), active low
// - wait output enabled by chip select, always low while deselected
// - select falling during unfinished window write or autoinc read shows busy
// - first half of a window read sends a fetch request on strobe fall
// - window read keeps wait high until fetched word loads the window
// - after second half window write or autoinc read, busy after strobe rises
// - other accesses keep wait low with no busy period, except a write held back by a full buffer
// - control and address register accesses leave wait untouched, except a write held back by a full buffer
// - select group sampled at strobe fall, or address strobe fall if used
// - write data captured at strobe rising edge
// - read drive starts only after strobe falls
// - read drive released after strobe rises
// - read data valid LEAD_CYC clock periods before wait drops, two by default
// - address strobe fall of a waiting access may raise wait
// - strobe low and high each at least four clock periods
// - data bits 8 and 4:3 are straps latched as reset releases
// - data bus stays undriven during reset
module hph_port #(
   parameter int LEAD_CYC = hph_pkg::DATA_LEAD_CYC
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic port_chip_select_n,
   input wire logic data_strobe_a,
   input wire logic data_strobe_b,
   input wire logic address_strobe_n,
   input wire logic [1:0] register_select,
   input wire logic read_not_write,
   input wire logic half_word_identify,
   input wire logic [15:0] host_data_bus_in,
   output logic [15:0] host_data_bus_out,
   output logic host_data_bus_oe,
   output logic port_wait_n,
   input wire logic [31:0] ctrl_rd_data,
   input wire logic [31:0] addr_rd_data,
   output logic fetch_req,
   input wire logic fetch_done,
   input wire logic [31:0] fetch_data,
   output logic wr_valid,
   output hph_pkg::hph_word_t wr_word,
   input wire logic wr_ready,
   output logic cfg_endian,
   output logic [hph_pkg::CFG_BOOT_W-1:0] cfg_boot_mode
);
   if (LEAD_CYC < 1 || LEAD_CYC > 2) begin : g_lead_check
      $error("LEAD_CYC must be 1 or 2");
   end

   function automatic logic is_window(input logic [1:0] sel);
      is_window = (sel == hph_pkg::SEL_WINDOW_AUTO) || (sel == hph_pkg::SEL_WINDOW_FIXED);
   endfunction

   function automatic logic [15:0] half_of(input logic [31:0] w, input logic hw);
      half_of = hw ? w[31:16] : w[15:0];
   endfunction

   logic [3:0] sync1_r, sync2_r;
   hph_pkg::hph_pin_t pin_d1_r, pin_d2_r;
   logic stb_r, stb_r_nxt, as_prev_r;
   hph_pkg::hph_select_t cur_r, cur_nxt;
   logic as_taken_r, as_taken_nxt, as_wait_r, as_wait_nxt;
   logic [15:0] first_half_r, first_half_nxt;
   logic [31:0] window_r, window_nxt;
   logic fetch_req_r, fetch_req_nxt, fetch_pend_r, fetch_pend_nxt, post_fetch_r, post_fetch_nxt;
   logic push_pend_r, push_pend_nxt;
   hph_pkg::hph_word_t push_word_r, push_word_nxt;
   logic [hph_pkg::LEAD_W-1:0] lead_r, lead_nxt;
   logic wait_r, wait_nxt, oe_r, oe_nxt;
   logic [15:0] dout_r, dout_nxt;
   logic boot_done_r, boot_done_nxt, endian_r, endian_nxt;
   logic [hph_pkg::CFG_BOOT_W-1:0] boot_r, boot_nxt;
   hph_pkg::hph_word_t head_r, head_nxt, spare_r, spare_nxt;
   logic head_v_r, head_v_nxt, spare_v_r, spare_v_nxt;
   logic stb_now, stb_fall, stb_rise, as_fall, busy_win;
   hph_pkg::hph_select_t s;

   // pins through two flops; select and data delayed alike to stay aligned
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r <= hph_pkg::SYN_RESET;
         sync2_r <= hph_pkg::SYN_RESET;
         pin_d1_r <= '0;
         pin_d2_r <= '0;
         as_prev_r <= 1'b1;
      end else begin
         sync1_r <= {address_strobe_n, data_strobe_b, data_strobe_a, port_chip_select_n};
         sync2_r <= sync1_r;
         pin_d1_r <= {register_select, read_not_write, half_word_identify, host_data_bus_in};
         pin_d2_r <= pin_d1_r;
         as_prev_r <= sync2_r[hph_pkg::SYN_AS];
      end
   end

   always_comb begin
      stb_now = sync2_r[hph_pkg::SYN_CS] | ~(sync2_r[hph_pkg::SYN_A] ^ sync2_r[hph_pkg::SYN_B]);
      stb_fall = stb_r & ~stb_now;
      stb_rise = ~stb_r & stb_now;
      as_fall = as_prev_r & ~sync2_r[hph_pkg::SYN_AS] & stb_r;
      s = as_taken_r ? cur_r : pin_d2_r.s;
      stb_r_nxt = stb_now;
      cur_nxt = cur_r;
      as_taken_nxt = as_taken_r;
      as_wait_nxt = as_wait_r;
      first_half_nxt = first_half_r;
      window_nxt = window_r;
      fetch_req_nxt = 1'b0;
      fetch_pend_nxt = fetch_pend_r;
      post_fetch_nxt = post_fetch_r;
      push_pend_nxt = push_pend_r;
      push_word_nxt = push_word_r;
      lead_nxt = (lead_r != '0) ? lead_r - 1'b1 : lead_r;
      oe_nxt = oe_r;
      dout_nxt = dout_r;
      boot_done_nxt = 1'b1;
      endian_nxt = endian_r;
      boot_nxt = boot_r;
      head_nxt = head_r;
      head_v_nxt = head_v_r;
      spare_nxt = spare_r;
      spare_v_nxt = spare_v_r;
      if (!boot_done_r) begin
         endian_nxt = host_data_bus_in[hph_pkg::CFG_ENDIAN_BIT];
         boot_nxt = host_data_bus_in[hph_pkg::CFG_BOOT_LSB +: hph_pkg::CFG_BOOT_W];
      end
      if (as_fall) begin
         cur_nxt = pin_d2_r.s;
         as_taken_nxt = 1'b1;
         as_wait_nxt = is_window(pin_d2_r.s.sel) && pin_d2_r.s.rnw && !pin_d2_r.s.hw;
      end
      if (stb_fall) begin
         cur_nxt = s;
         as_wait_nxt = 1'b0;
         if (s.rnw) begin
            oe_nxt = 1'b1;
            if (s.sel == hph_pkg::SEL_CONTROL) begin
               dout_nxt = half_of(ctrl_rd_data, s.hw);
            end else if (s.sel == hph_pkg::SEL_ADDRESS) begin
               dout_nxt = half_of(addr_rd_data, s.hw);
            end else begin
               dout_nxt = half_of(window_r, s.hw);
            end
            if (is_window(s.sel) && !s.hw) begin
               fetch_req_nxt = 1'b1;
               fetch_pend_nxt = 1'b1;
            end
         end
      end
      if (stb_rise) begin
         as_taken_nxt = 1'b0;
         as_wait_nxt = 1'b0;
         oe_nxt = 1'b0;
         if (!cur_r.rnw && !cur_r.hw) begin
            first_half_nxt = pin_d2_r.data;
         end else if (!cur_r.rnw) begin
            push_pend_nxt = 1'b1;
            push_word_nxt = '{sel: cur_r.sel, data: {pin_d2_r.data, first_half_r}};
         end else if (cur_r.hw && cur_r.sel == hph_pkg::SEL_WINDOW_AUTO) begin
            fetch_req_nxt = 1'b1;
            post_fetch_nxt = 1'b1;
         end
      end
      if (fetch_done && (fetch_pend_r || post_fetch_r)) begin
         window_nxt = fetch_data;
         post_fetch_nxt = 1'b0;
         fetch_pend_nxt = 1'b0;
         if (fetch_pend_r && oe_nxt) begin
            dout_nxt = fetch_data[15:0];
            lead_nxt = LEAD_CYC[hph_pkg::LEAD_W-1:0];
         end
      end
      // two-entry buffer toward the internal engine
      if (head_v_r && wr_ready) begin
         head_v_nxt = 1'b0;
      end
      if (!head_v_nxt && spare_v_r) begin
         head_nxt = spare_r;
         head_v_nxt = 1'b1;
         spare_v_nxt = 1'b0;
      end
      if (push_pend_r && !spare_v_nxt) begin
         push_pend_nxt = stb_rise && !cur_r.rnw && cur_r.hw;
         if (!head_v_nxt) begin
            head_nxt = push_word_r;
            head_v_nxt = 1'b1;
         end else begin
            spare_nxt = push_word_r;
            spare_v_nxt = 1'b1;
         end
      end
      // window work shows busy, as does a write held back by a full buffer; other register writes drain silently
      busy_win = post_fetch_nxt | (push_pend_nxt & (push_pend_r | is_window(push_word_nxt.sel)))
         | (head_v_nxt & is_window(head_nxt.sel)) | (spare_v_nxt & is_window(spare_nxt.sel));
      wait_nxt = ~sync2_r[hph_pkg::SYN_CS] & (fetch_pend_nxt | (lead_nxt != '0) | busy_win | as_wait_nxt);
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stb_r <= 1'b1;
         cur_r <= '0;
         as_taken_r <= 1'b0;
         as_wait_r <= 1'b0;
         first_half_r <= hph_pkg::DATA_RESET;
         window_r <= hph_pkg::WORD_RESET;
         fetch_req_r <= 1'b0;
         fetch_pend_r <= 1'b0;
         post_fetch_r <= 1'b0;
         push_pend_r <= 1'b0;
         push_word_r <= '0;
         lead_r <= '0;
         wait_r <= 1'b0;
         oe_r <= 1'b0;
         dout_r <= hph_pkg::DATA_RESET;
         boot_done_r <= 1'b0;
         endian_r <= 1'b0;
         boot_r <= '0;
         head_r <= '0;
         head_v_r <= 1'b0;
         spare_r <= '0;
         spare_v_r <= 1'b0;
      end else begin
         stb_r <= stb_r_nxt;
         cur_r <= cur_nxt;
         as_taken_r <= as_taken_nxt;
         as_wait_r <= as_wait_nxt;
         first_half_r <= first_half_nxt;
         window_r <= window_nxt;
         fetch_req_r <= fetch_req_nxt;
         fetch_pend_r <= fetch_pend_nxt;
         post_fetch_r <= post_fetch_nxt;
         push_pend_r <= push_pend_nxt;
         push_word_r <= push_word_nxt;
         lead_r <= lead_nxt;
         wait_r <= wait_nxt;
         oe_r <= oe_nxt;
         dout_r <= dout_nxt;
         boot_done_r <= boot_done_nxt;
         endian_r <= endian_nxt;
         boot_r <= boot_nxt;
         head_r <= head_nxt;
         head_v_r <= head_v_nxt;
         spare_r <= spare_nxt;
         spare_v_r <= spare_v_nxt;
      end
   end

   assign host_data_bus_out = dout_r;
   assign host_data_bus_oe = oe_r;
   assign port_wait_n = wait_r;
   assign fetch_req = fetch_req_r;
   assign wr_valid = head_v_r;
   assign wr_word = head_r;
   assign cfg_endian = endian_r;
   assign cfg_boot_mode = boot_r;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   sequence seq_win_read_first;
      stb_fall && s.rnw && !s.hw && is_window(s.sel);
   endsequence

   sequence seq_auto_read_second;
      stb_rise && cur_r.rnw && cur_r.hw && cur_r.sel == hph_pkg::SEL_WINDOW_AUTO;
   endsequence

   a_wait_deselect: assert property (sync2_r[hph_pkg::SYN_CS] |=> !port_wait_n)
      else $error("wait high while deselected");
   a_fetch_first_half: assert property (seq_win_read_first |=> fetch_req && fetch_pend_r)
      else $error("no fetch on first half window read");
   a_wait_fetch: assert property (fetch_pend_r && !sync2_r[hph_pkg::SYN_CS] |=> port_wait_n)
      else $error("wait low before window loaded");
   a_data_lead: assert property (fetch_pend_r && fetch_done && oe_r && !stb_rise && !sync2_r[hph_pkg::SYN_CS]
      |=> port_wait_n && host_data_bus_out == $past(fetch_data[15:0]))
      else $error("read data not ahead of ready");
   a_prefetch_busy: assert property ((seq_auto_read_second and !sync2_r[hph_pkg::SYN_CS])
      |=> fetch_req ##0 port_wait_n)
      else $error("no prefetch busy after autoinc read");
   a_drive_start: assert property ($rose(host_data_bus_oe) |-> $past(stb_fall) && $past(s.rnw))
      else $error("drive began without strobe fall");
   a_drive_release: assert property (stb_rise |=> !host_data_bus_oe)
      else $error("drive kept after strobe rise");
   a_write_capture: assert property (stb_rise && !cur_r.rnw && cur_r.hw
      |=> push_pend_r && push_word_r.data[31:16] == $past(pin_d2_r.data))
      else $error("write half not captured at strobe rise");
   a_quiet_access: assert property (stb_fall && !is_window(s.sel) && !port_wait_n && !push_pend_r && !head_v_r
      && !spare_v_r && !post_fetch_r && !fetch_pend_r && lead_r == '0 |=> !port_wait_n)
      else $error("busy on a non window access");
   a_strap_latch: assert property ($rose(boot_done_r)
      |-> cfg_endian == $past(host_data_bus_in[hph_pkg::CFG_ENDIAN_BIT]))
      else $error("strap not latched at reset release");
   a_cs_busy: assert property ($fell(sync2_r[hph_pkg::SYN_CS]) && (post_fetch_r && !fetch_done
      || push_pend_r && is_window(push_word_r.sel) || head_v_r && !wr_ready && is_window(head_r.sel)
      || spare_v_r && is_window(spare_r.sel)) |=> port_wait_n)
      else $error("no busy on select during pending work");
endmodule // hph_port
`default_nettype wire

// File: bench/hph_host_model.sv
// host processor model driving the port pins
`timescale 1ns/1ns
`default_nettype none
module hph_host_model (
   input wire logic clk_sys,
   input wire logic port_wait_n,
   input wire logic [15:0] bus_in,
   output logic cs_n,
   output logic stb_a,
   output logic stb_b,
   output logic as_n,
   output hph_pkg::hph_select_t sel,
   output logic [15:0] drv,
   output logic drv_oe
);
   logic use_as;

   initial begin
      use_as = 1'b0;
      as_n = 1'b1;
      cs_n = 1'b1;
      stb_a = 1'b1;
      stb_b = 1'b1;
      sel = '0;
      drv = 16'h0000;
      drv_oe = 1'b0;
   end

   // one half-word access; n counts strobe-low cycles, 300 means hung
   task automatic acc(input hph_pkg::hph_select_t s, input logic [15:0] wd, input logic use_b,
      output logic [15:0] rd, output logic pre, output logic post, output int n);
      pre = 1'b0;
      post = 1'b0;
      n = 0;
      @(negedge clk_sys);
      sel = s;
      cs_n = 1'b0;
      drv = ~wd;
      drv_oe = !s.rnw;
      repeat (5) @(negedge clk_sys);
      while (port_wait_n !== 1'b0 && n < 200) begin
         pre = 1'b1;
         n++;
         @(negedge clk_sys);
      end
      n = (n >= 200) ? 300 : 0;
      if (use_as) begin
         as_n = 1'b0;
         repeat (4) @(negedge clk_sys);
         pre |= (port_wait_n === 1'b1);
         sel = ~s;
      end
      if (use_b)
         stb_b = 1'b0;
      else
         stb_a = 1'b0;
      do begin
         @(posedge clk_sys);
         n++;
      end while ((n < 4 || port_wait_n !== 1'b0) && n < 300);
      rd = bus_in;
      @(negedge clk_sys);
      drv = wd;
      @(negedge clk_sys);
      stb_a = 1'b1;
      stb_b = 1'b1;
      as_n = 1'b1;
      repeat (6) begin
         @(negedge clk_sys);
         post |= (port_wait_n === 1'b1);
      end
      cs_n = 1'b1;
      drv_oe = 1'b0;
   endtask
endmodule // hph_host_model
`default_nettype wire

// File: bench/hph_port_tb.sv
// self-checking bench of the host port handshake
`timescale 1ns/1ns
`default_nettype none
module hph_port_tb;
   localparam logic [31:0] CTRL_V = 32'hC0DE_1234;
   localparam logic [31:0] ADDR_V = 32'hADD0_5678;
   logic clk_sys, rst_n, cs_n, stb_a, stb_b, wait_n, dev_oe, drv_oe, fetch_req, fetch_done;
   logic wr_valid, wr_ready, cfg_endian, as_n;
   logic [1:0] boot;
   logic [15:0] bus, dev_out, drv, flt;
   logic [31:0] eng_word;
   hph_pkg::hph_select_t sel;
   hph_pkg::hph_word_t wr_word;
   hph_pkg::hph_word_t got[$];
   int eng_delay, fetch_cnt, fetch_reqs, error_cnt, total_checks;

   // undriven bus shows a toggling pattern, never the last value
   assign bus = dev_oe ? dev_out : (drv_oe ? drv : flt);

   hph_host_model hph_host_model_inst (.clk_sys(clk_sys), .port_wait_n(wait_n), .bus_in(bus),
      .cs_n(cs_n), .stb_a(stb_a), .stb_b(stb_b), .as_n(as_n), .sel(sel), .drv(drv), .drv_oe(drv_oe));

   hph_port hph_port_inst (.clk_sys(clk_sys), .rst_n(rst_n), .port_chip_select_n(cs_n),
      .data_strobe_a(stb_a), .data_strobe_b(stb_b), .address_strobe_n(as_n),
      .register_select(sel.sel), .read_not_write(sel.rnw), .half_word_identify(sel.hw),
      .host_data_bus_in(bus), .host_data_bus_out(dev_out), .host_data_bus_oe(dev_oe),
      .port_wait_n(wait_n), .ctrl_rd_data(CTRL_V), .addr_rd_data(ADDR_V), .fetch_req(fetch_req),
      .fetch_done(fetch_done), .fetch_data(eng_word), .wr_valid(wr_valid), .wr_word(wr_word),
      .wr_ready(wr_ready), .cfg_endian(cfg_endian), .cfg_boot_mode(boot));

   initial begin
      clk_sys = 1'b1;
      forever #25 clk_sys = ~clk_sys;
   end

   // transfer engine answering each fetch after eng_delay cycles
   always @(negedge clk_sys) begin
      flt <= ~flt;
      fetch_done <= (fetch_cnt == 1);
      if (fetch_cnt != 0)
         fetch_cnt <= fetch_cnt - 1;
      if (fetch_req === 1'b1) begin
         fetch_cnt <= eng_delay;
         fetch_reqs <= fetch_reqs + 1;
      end
   end

   always @(posedge clk_sys)
      if (wr_valid === 1'b1 && wr_ready === 1'b1)
         got.push_back(wr_word);

   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic complete_run;
      if (error_cnt == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic hacc(input logic [1:0] s, input logic rnw, input logic hw, input logic [15:0] wd,
      output logic [15:0] rd, output logic pre, output logic post);
      int n;
      hph_host_model_inst.acc(hph_pkg::hph_select_t'{s, rnw, hw}, wd, hw, rd, pre, post, n);
      repeat (4) @(negedge clk_sys);
      check({dev_oe, wait_n}, 2'b00);
      if (n >= 300) begin
         error_cnt++;
         complete_run();
      end
   endtask

   task automatic t_write;
      logic [15:0] rd;
      logic pre, post;
      wr_ready = 1'b0;
      hacc(hph_pkg::SEL_WINDOW_AUTO, 1'b0, 1'b0, 16'h3C5A, rd, pre, post);
      hacc(hph_pkg::SEL_WINDOW_AUTO, 1'b0, 1'b1, 16'h96E1, rd, pre, post);
      check(post, 1'b1);
      fork
         begin
            repeat (30) @(negedge clk_sys);
            wr_ready = 1'b1;
         end
      join_none
      hacc(hph_pkg::SEL_CONTROL, 1'b1, 1'b0, 16'h0000, rd, pre, post);
      check({pre, post, rd}, {2'b10, CTRL_V[15:0]});
      check(got.size(), 1);
      check(got.pop_front(), {hph_pkg::SEL_WINDOW_AUTO, 32'h96E1_3C5A});
   endtask

   task automatic t_read(input logic [1:0] s, input int dly);
      logic [15:0] rd;
      logic pre, post;
      int k;
      eng_word = 32'hBEEF_0F1E + dly;
      eng_delay = dly;
      k = fetch_reqs;
      hacc(s, 1'b1, 1'b0, 16'h0000, rd, pre, post);
      check({fetch_reqs == k + 1, rd}, {1'b1, eng_word[15:0]});
      hacc(s, 1'b1, 1'b1, 16'h0000, rd, pre, post);
      check(rd, eng_word[31:16]);
      check({post, fetch_reqs - k}, {s == hph_pkg::SEL_WINDOW_AUTO, 32'd1 + (s == hph_pkg::SEL_WINDOW_AUTO)});
      repeat (dly + 4) @(negedge clk_sys);
   endtask

   task automatic t_regs;
      logic [15:0] rd;
      logic pre, post;
      for (int h = 0; h < 2; h++) begin
         hacc(hph_pkg::SEL_ADDRESS, 1'b0, h[0], ADDR_V[h*16 +: 16] ^ 16'h0F0F, rd, pre, post);
         check({pre, post}, 2'b00);
      end
      for (int h = 0; h < 2; h++) begin
         hacc(hph_pkg::SEL_ADDRESS, 1'b1, h[0], 16'h0000, rd, pre, post);
         check({pre, post, rd}, {2'b00, ADDR_V[h*16 +: 16]});
      end
      check(got.pop_front(), {hph_pkg::SEL_ADDRESS, ADDR_V ^ 32'h0F0F_0F0F});
   endtask

   // select latched at address strobe fall, pins scrambled before the strobe
   task automatic t_as;
      logic [15:0] rd;
      logic pre, post;
      int k;
      hph_host_model_inst.use_as = 1'b1;
      eng_word = 32'h5A5A_C3C3;
      eng_delay = 3;
      k = fetch_reqs;
      hacc(hph_pkg::SEL_WINDOW_FIXED, 1'b1, 1'b0, 16'h0000, rd, pre, post);
      check({pre, fetch_reqs == k + 1, rd}, {2'b11, eng_word[15:0]});
      hacc(hph_pkg::SEL_ADDRESS, 1'b1, 1'b1, 16'h0000, rd, pre, post);
      check({pre, post, rd}, {2'b00, ADDR_V[31:16]});
      hph_host_model_inst.use_as = 1'b0;
   endtask

   task automatic t_no_strobe;
      int k;
      k = fetch_reqs;
      for (int i = 0; i < 2; i++) begin
         @(negedge clk_sys);
         hph_host_model_inst.sel = hph_pkg::hph_select_t'{hph_pkg::SEL_WINDOW_FIXED, 1'b1, 1'b0};
         hph_host_model_inst.cs_n = i[0];
         hph_host_model_inst.stb_a = 1'b0;
         hph_host_model_inst.stb_b = i[0];
         repeat (8) @(negedge clk_sys);
         check({dev_oe, fetch_reqs == k}, 2'b01);
         hph_host_model_inst.cs_n = 1'b1;
         hph_host_model_inst.stb_a = 1'b1;
         hph_host_model_inst.stb_b = 1'b1;
         repeat (6) @(negedge clk_sys);
      end
   endtask

   initial begin
      rst_n = 1'b0;
      wr_ready = 1'b1;
      eng_word = 32'h0000_0000;
      eng_delay = 1;
      fetch_cnt = 0;
      fetch_reqs = 0;
      fetch_done = 1'b0;
      flt = 16'hA5A5;
      error_cnt = 0;
      total_checks = 0;
      #1;
      hph_host_model_inst.drv = 16'h0110;
      hph_host_model_inst.drv_oe = 1'b1;
      repeat (10) @(negedge clk_sys);
      check(dev_oe, 1'b0);
      rst_n = 1'b1;
      repeat (3) @(negedge clk_sys);
      hph_host_model_inst.drv_oe = 1'b0;
      check({cfg_endian, boot}, 3'b110);
      t_write();
      t_read(hph_pkg::SEL_WINDOW_FIXED, 20);
      t_read(hph_pkg::SEL_WINDOW_AUTO, 1);
      t_regs();
      t_as();
      t_no_strobe();
      complete_run();
   end
endmodule // hph_port_tb
`default_nettype wire
